// File: core/rtc_pkg.sv
// Constants, bus carriers and state layout for the real-time clock timebase core.
// Assumes a 10 MHz system clock and a 32.768 kHz reference sampled on xtal_in.
// Summary of operation
// - Fifteen divide-by-two stages turn the 32.768 kHz reference into a 1 Hz tick.
// - Divider control bits 6-4 of control A steer counting, reset, bank and oscillator.
// - Divider counts only with divider control code 01X or 100.
// - First update comes 500 ms after the divider starts counting.
// - Rate select bits 3-0 of control A pick the periodic tap.
// - First periodic flag comes half a period after divider start.
// - Control B bit 2 picks binary or BCD, bit 1 picks 24 or 12 hour.
// - February has 29 days every fourth year, year 2000 included.
// - Daylight saving changes are applied automatically when enabled.
// - Internal time advances every second even while freeze is set.
// - Setting freeze snapshots time into user copies; bus then touches only copies.
// - Clearing freeze loads user copies into time between two updates.
// - Control C bit 4 flags each update end; control B bit 4 enables it.
// - Update-pending bit 7 of control A rises 244 us before each update.
// - Control B bit 6 enables periodic interrupt; periodic precedes update by half period.
// - After each update all seven fields match the alarm to set control C bit 5.
// - Alarm match drives the open-drain host interrupt low while control B bit 5 enables it.
// - Alarm byte with top bits 11 matches any value.
// - Reading control C clears its flags and releases the host interrupt.
// - Control A writes are ignored while the valid RAM and time bit is 0.
// - Code 00X stops the oscillator once main power is gone.
package rtc_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_type;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SEC = 6'h00;
  localparam logic [5:0] IDX_SEC_ALM = 6'h01;
  localparam logic [5:0] IDX_MIN = 6'h02;
  localparam logic [5:0] IDX_MIN_ALM = 6'h03;
  localparam logic [5:0] IDX_HOUR = 6'h04;
  localparam logic [5:0] IDX_HOUR_ALM = 6'h05;
  localparam logic [5:0] IDX_WDAY = 6'h06;
  localparam logic [5:0] IDX_DATE = 6'h07;
  localparam logic [5:0] IDX_MONTH = 6'h08;
  localparam logic [5:0] IDX_YEAR = 6'h09;
  localparam logic [5:0] IDX_CTRL_A = 6'h0A;
  localparam logic [5:0] IDX_CTRL_B = 6'h0B;
  localparam logic [5:0] IDX_CTRL_C = 6'h0C;
  localparam logic [5:0] IDX_CTRL_D = 6'h0D;
  localparam logic [5:0] IDX_WDAY_ALM = 6'h0E;
  localparam logic [5:0] IDX_DATE_ALM = 6'h0F;
  localparam logic [5:0] IDX_MONTH_ALM = 6'h10;
  localparam logic [5:0] IDX_YEAR_ALM = 6'h11;

  // Field positions
  localparam int CRA_UIP_BIT = 7;
  localparam int CRA_DV_LSB = 4;
  localparam int CRB_SET_BIT = 7;
  localparam int CRB_PIE_BIT = 6;
  localparam int CRB_AIE_BIT = 5;
  localparam int CRB_UIE_BIT = 4;
  localparam int CRB_DM_BIT = 2;
  localparam int CRB_H24_BIT = 1;
  localparam int CRB_DSE_BIT = 0;
  localparam int CRD_VRT_BIT = 7;

  // Reset values
  localparam logic [6:0] CTRL_A_RESET = 7'h20;
  localparam logic [7:0] CTRL_B_RESET = 8'h02;
  localparam logic [55:0] TIME_RESET = 56'h00_0101_0100_0000;

  // Timebase
  localparam int DIV_W = 15;
  localparam int XTAL_HZ = 32768;
  localparam int FIRST_UPDATE_MS = 500;
  localparam int FIRST_UPDATE_TICKS = FIRST_UPDATE_MS * XTAL_HZ / 1000;
  localparam int UIP_LEAD_NS = 244000;
  localparam int UIP_LEAD_TICKS =
    int'((longint'(UIP_LEAD_NS) * XTAL_HZ + 64'd999999999) / 64'd1000000000);
  localparam logic [DIV_W-1:0] DIV_LAST = 15'h7FFF;
  localparam logic [DIV_W-1:0] DIV_FIRST = DIV_W'((1 << DIV_W) - FIRST_UPDATE_TICKS);
  localparam logic [DIV_W-1:0] UIP_START = DIV_W'((1 << DIV_W) - UIP_LEAD_TICKS);

  // Calendar
  localparam logic [1:0] ALM_ANY = 2'h3;
  localparam logic [7:0] SUNDAY = 8'h01;
  localparam logic [6:0] DST_SPRING_MONTH = 7'd4;
  localparam logic [6:0] DST_SPRING_LAST_DATE = 7'd7;
  localparam logic [6:0] DST_FALL_MONTH = 7'd10;
  localparam logic [6:0] DST_FALL_FIRST_DATE = 7'd25;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic [6:0] rtc_control_a;
    logic update_pending;
    logic [7:0] rtc_control_b;
    logic pf;
    logic af;
    logic uf;
    logic valid_ram_time;
    logic [6:0][7:0] tm;
    logic [6:0][7:0] usr;
    logic [6:0][7:0] alm;
    logic [DIV_W-1:0] div;
    logic run_prev;
    logic xtal_prev;
    logic pend;
    logic alarm_chk;
    logic dst_done;
    logic irq_oe;
    logic xtal_out;
    logic [1:0] bank;
  } state_type;

  localparam state_type STATE_RESET = '{rtc_control_a: CTRL_A_RESET, rtc_control_b: CTRL_B_RESET,
    tm: TIME_RESET, usr: TIME_RESET, default: '0};

endpackage

// File: core/rtc_timebase_update_alarm.sv
// Timekeeping core: divider chain, calendar, double-buffered update, alarm, host interrupt.
// Assumes a classic Wishbone master with 32-bit data and xtal_in synchronous to clk.
`timescale 1ns/1ps
module rtc_timebase_update_alarm (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register bus
  input rtc_pkg::wb_req_type wb_req,
  output rtc_pkg::wb_rsp_type wb_rsp,
  // Reference oscillator
  input wire logic xtal_in,
  output logic xtal_out,
  // Power status
  input wire logic main_power_ok,
  input wire logic vrt_in,
  // Host interrupt, open drain
  output logic rtc_host_irq_n_o,
  output logic rtc_host_irq_n_oe,
  // Bank selection
  output logic [1:0] bank_select
);
  import rtc_pkg::*;

  state_type s_q;
  state_type s_d;

  logic [2:0] dv;
  logic [3:0] rs;
  logic bcd;
  logic h24;
  logic run;
  logic osc_on;
  logic tick;
  logic update;
  logic per_evt;
  logic alarm_hit;
  logic acc;
  logic [5:0] idx;
  logic [3:0] tslot;
  logic [3:0] aslot;
  logic [DIV_W-1:0] mask;
  logic [DIV_W-1:0] half;
  logic [6:0][7:0] t;
  logic c_min;
  logic c_hour;
  logic c_day;
  logic c_mon;
  logic c_year;
  logic pm;
  logic at_1_59_59;
  logic [7:0] enc12;
  logic any_irq_flag;

  function automatic logic [6:0] to_bin(input logic [7:0] v, input logic b);
    if (b) begin
      to_bin = {3'h0, v[7:4]} * 7'd10 + {3'h0, v[3:0]};
    end else begin
      to_bin = v[6:0];
    end
  endfunction

  function automatic logic [7:0] from_bin(input logic [6:0] n, input logic b);
    if (b) begin
      from_bin = {4'(n / 7'd10), 4'(n % 7'd10)};
    end else begin
      from_bin = {1'b0, n};
    end
  endfunction

  function automatic logic [7:0] inc_val(input logic [7:0] v, input logic b);
    if (b && v[3:0] == 4'h9) begin
      inc_val = {v[7:4] + 4'h1, 4'h0};
    end else begin
      inc_val = v + 8'h01;
    end
  endfunction

  function automatic logic [6:0] month_days(input logic [6:0] m, input logic [6:0] y);
    case (m)
      7'd2: month_days = (y[1:0] == 2'b00) ? 7'd29 : 7'd28;
      7'd4, 7'd6, 7'd9, 7'd11: month_days = 7'd30;
      default: month_days = 7'd31;
    endcase
  endfunction

  // Returns {valid, slot}; slots run sec, min, hour, weekday, date, month, year
  function automatic logic [3:0] time_slot(input logic [5:0] i);
    case (i)
      IDX_SEC: time_slot = 4'h8;
      IDX_MIN: time_slot = 4'h9;
      IDX_HOUR: time_slot = 4'hA;
      IDX_WDAY: time_slot = 4'hB;
      IDX_DATE: time_slot = 4'hC;
      IDX_MONTH: time_slot = 4'hD;
      IDX_YEAR: time_slot = 4'hE;
      default: time_slot = 4'h0;
    endcase
  endfunction

  function automatic logic [3:0] alarm_slot(input logic [5:0] i);
    case (i)
      IDX_SEC_ALM: alarm_slot = 4'h8;
      IDX_MIN_ALM: alarm_slot = 4'h9;
      IDX_HOUR_ALM: alarm_slot = 4'hA;
      IDX_WDAY_ALM: alarm_slot = 4'hB;
      IDX_DATE_ALM: alarm_slot = 4'hC;
      IDX_MONTH_ALM: alarm_slot = 4'hD;
      IDX_YEAR_ALM: alarm_slot = 4'hE;
      default: alarm_slot = 4'h0;
    endcase
  endfunction

  always_comb begin
    s_d = s_q;
    dv = s_q.rtc_control_a[CRA_DV_LSB +: 3];
    rs = s_q.rtc_control_a[3:0];
    bcd = ~s_q.rtc_control_b[CRB_DM_BIT];
    h24 = s_q.rtc_control_b[CRB_H24_BIT];
    idx = wb_req.adr[7:2];
    tslot = time_slot(idx);
    aslot = alarm_slot(idx);
    acc = wb_req.cyc & wb_req.stb;
    update = 1'b0;
    per_evt = 1'b0;
    alarm_hit = 1'b1;
    t = s_q.tm;
    c_min = 1'b0;
    c_hour = 1'b0;
    c_day = 1'b0;
    c_mon = 1'b0;
    c_year = 1'b0;
    pm = s_q.tm[2][7];
    enc12 = from_bin(7'd12, bcd);
    at_1_59_59 = 1'b0;
    mask = '0;
    half = '0;

    // Oscillator held off only in storage code with main power gone
    osc_on = ~(dv[2:1] == 2'b00 && ~main_power_ok);
    s_d.xtal_out = osc_on & ~xtal_in;
    s_d.xtal_prev = xtal_in;
    tick = xtal_in & ~s_q.xtal_prev & osc_on;
    run = (dv[2:1] == 2'b01) || (dv == 3'b100);
    s_d.run_prev = run;
    s_d.bank = dv[2] ? 2'd2 : {1'b0, dv[0]};
    s_d.valid_ram_time = vrt_in;

    // Divider chain; start at half scale so the first wrap is 500 ms away
    if (dv[2:1] == 2'b11) begin
      s_d.div = '0;
    end else if (run && !s_q.run_prev) begin
      s_d.div = DIV_FIRST;
    end else if (run && tick) begin
      s_d.div = s_q.div + 15'h0001;
      update = (s_q.div == DIV_LAST);
      if (rs == 4'h1) begin
        per_evt = 1'b1;
      end else if (rs != 4'h0) begin
        mask = (15'h0001 << (rs - 4'h1)) - 15'h0001;
        half = 15'h0001 << (rs - 4'h2);
        per_evt = ((s_d.div & mask) == half);
      end
    end
    s_d.update_pending = run && (s_d.div >= UIP_START);

    // One-second advance runs regardless of freeze
    if (update) begin
      at_1_59_59 = to_bin(t[0], bcd) == 7'd59 && to_bin(t[1], bcd) == 7'd59 &&
        t[2] == 8'h01 && t[3] == SUNDAY;
      if (to_bin(t[0], bcd) >= 7'd59) begin
        t[0] = 8'h00;
        c_min = 1'b1;
      end else begin
        t[0] = inc_val(t[0], bcd);
      end
      if (c_min) begin
        if (to_bin(t[1], bcd) >= 7'd59) begin
          t[1] = 8'h00;
          c_hour = 1'b1;
        end else begin
          t[1] = inc_val(t[1], bcd);
        end
      end
      if (c_hour) begin
        if (h24) begin
          if (to_bin(t[2], bcd) >= 7'd23) begin
            t[2] = 8'h00;
            c_day = 1'b1;
          end else begin
            t[2] = inc_val(t[2], bcd);
          end
        end else if (to_bin({1'b0, t[2][6:0]}, bcd) == 7'd11) begin
          t[2] = {~pm, enc12[6:0]};
          c_day = pm;
        end else if (to_bin({1'b0, t[2][6:0]}, bcd) >= 7'd12) begin
          t[2] = {pm, 7'h01};
        end else begin
          t[2] = inc_val(t[2], bcd);
        end
      end
      // Spring forward skips 2:00; fall back repeats 1:00 once
      if (s_q.rtc_control_b[CRB_DSE_BIT] && at_1_59_59) begin
        if (to_bin(t[5], bcd) == DST_SPRING_MONTH &&
            to_bin(t[4], bcd) <= DST_SPRING_LAST_DATE) begin
          t[2] = 8'h03;
        end else if (to_bin(t[5], bcd) == DST_FALL_MONTH &&
            to_bin(t[4], bcd) >= DST_FALL_FIRST_DATE && !s_q.dst_done) begin
          t[2] = 8'h01;
          s_d.dst_done = 1'b1;
        end
      end
      if (to_bin(t[5], bcd) != DST_FALL_MONTH) begin
        s_d.dst_done = 1'b0;
      end
      if (c_day) begin
        t[3] = (to_bin(t[3], bcd) >= 7'd7) ? 8'h01 : inc_val(t[3], bcd);
        if (to_bin(t[4], bcd) >= month_days(to_bin(t[5], bcd), to_bin(t[6], bcd))) begin
          t[4] = 8'h01;
          c_mon = 1'b1;
        end else begin
          t[4] = inc_val(t[4], bcd);
        end
      end
      if (c_mon) begin
        if (to_bin(t[5], bcd) >= 7'd12) begin
          t[5] = 8'h01;
          c_year = 1'b1;
        end else begin
          t[5] = inc_val(t[5], bcd);
        end
      end
      if (c_year) begin
        t[6] = (to_bin(t[6], bcd) >= 7'd99) ? 8'h00 : inc_val(t[6], bcd);
      end
      s_d.tm = t;
    end else if (s_q.pend) begin
      // Never in an update cycle, so the load lands between two seconds
      s_d.tm = s_q.usr;
      s_d.pend = 1'b0;
    end

    // Alarm compare one cycle after the update, on settled counters
    s_d.alarm_chk = update;
    for (int i = 0; i < 7; i++) begin
      if (s_q.alm[i][7:6] != ALM_ANY && s_q.alm[i] != s_q.tm[i]) begin
        alarm_hit = 1'b0;
      end
    end

    // Bus: answer one cycle after the request, act on the edge that sees ack
    s_d.ack = acc & ~s_q.ack;
    if (acc && !s_q.ack) begin
      s_d.rdata = 8'h00;
      if (tslot[3]) begin
        s_d.rdata = s_q.rtc_control_b[CRB_SET_BIT] ? s_q.usr[tslot[2:0]] : s_q.tm[tslot[2:0]];
      end else if (aslot[3]) begin
        s_d.rdata = s_q.alm[aslot[2:0]];
      end else if (idx == IDX_CTRL_A) begin
        s_d.rdata = {s_q.update_pending, s_q.rtc_control_a};
      end else if (idx == IDX_CTRL_B) begin
        s_d.rdata = s_q.rtc_control_b;
      end else if (idx == IDX_CTRL_C) begin
        s_d.rdata = {s_q.irq_oe, s_q.pf, s_q.af, s_q.uf, 4'h0};
      end else if (idx == IDX_CTRL_D) begin
        s_d.rdata = {s_q.valid_ram_time, 7'h00};
      end
    end
    if (acc && s_q.ack && !wb_req.we && idx == IDX_CTRL_C) begin
      s_d.pf = 1'b0;
      s_d.af = 1'b0;
      s_d.uf = 1'b0;
    end
    if (acc && s_q.ack && wb_req.we && wb_req.sel[0]) begin
      if (tslot[3]) begin
        if (s_q.rtc_control_b[CRB_SET_BIT]) begin
          s_d.usr[tslot[2:0]] = wb_req.dat[7:0];
        end else begin
          s_d.tm[tslot[2:0]] = wb_req.dat[7:0];
        end
      end else if (aslot[3]) begin
        s_d.alm[aslot[2:0]] = wb_req.dat[7:0];
      end else if (idx == IDX_CTRL_A) begin
        if (s_q.valid_ram_time) begin
          s_d.rtc_control_a = wb_req.dat[6:0];
        end
      end else if (idx == IDX_CTRL_B) begin
        s_d.rtc_control_b = wb_req.dat[7:0];
        if (wb_req.dat[CRB_SET_BIT] && !s_q.rtc_control_b[CRB_SET_BIT]) begin
          s_d.usr = s_q.tm;
        end
        if (!wb_req.dat[CRB_SET_BIT] && s_q.rtc_control_b[CRB_SET_BIT]) begin
          s_d.pend = 1'b1;
        end
      end
    end

    // Flag sets come last so an event beats a simultaneous clear
    if (per_evt) begin
      s_d.pf = 1'b1;
    end
    if (update) begin
      s_d.uf = 1'b1;
    end
    if (s_q.alarm_chk && alarm_hit) begin
      s_d.af = 1'b1;
    end
    any_irq_flag = (s_d.pf & s_d.rtc_control_b[CRB_PIE_BIT]) | (s_d.af & s_d.rtc_control_b[CRB_AIE_BIT]) |
      (s_d.uf & s_d.rtc_control_b[CRB_UIE_BIT]);
    s_d.irq_oe = any_irq_flag;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_rsp = '{ack: s_q.ack, dat: {24'h00_0000, s_q.rdata}};
  assign xtal_out = s_q.xtal_out;
  assign rtc_host_irq_n_o = 1'b0;
  assign rtc_host_irq_n_oe = s_q.irq_oe;
  assign bank_select = s_q.bank;

endmodule

// File: bench/ref_osc_model.sv
// Reference oscillator and host interrupt pull-up facing the timekeeping core.
// Assumes one reference toggle per bench clock is fast enough for the core's sampler.
`timescale 1ns/1ps
module ref_osc_model (
  // Clock
  input wire logic clk,
  // Reference
  output logic xtal,
  // Host interrupt pin
  input wire logic irq_o,
  input wire logic irq_oe,
  output logic irq_wire
);
  // Free running, like a crystal; one tick every two bench clocks keeps runs short
  initial xtal = 1'b0;
  always @(posedge clk) xtal <= ~xtal;
  // External pull-up holds the released line high
  assign irq_wire = irq_oe ? irq_o : 1'b1;
endmodule

// File: bench/rtc_core_checker.sv
// Port checker for the timekeeping core: bus handshake, interrupt pin, bank, oscillator.
// Assumes it is bound to the core and sees only the core's ports.
`timescale 1ns/1ps
module rtc_core_checker
  import rtc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register bus
  input rtc_pkg::wb_req_type wb_req,
  input rtc_pkg::wb_rsp_type wb_rsp,
  // Oscillator, interrupt, bank
  input wire logic xtal_in,
  input wire logic xtal_out,
  input wire logic rtc_host_irq_n_o,
  input wire logic rtc_host_irq_n_oe,
  input wire logic [1:0] bank_select
);
  logic req;
  assign req = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ack_one_cycle_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack stood longer than one cycle");
  ack_answer_a: assert property (req |=> wb_rsp.ack)
    else $error("request not answered next cycle");
  ack_cause_a: assert property (wb_rsp.ack |-> $past(req))
    else $error("ack without request");
  upper_zero_a: assert property (wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  unmapped_read_a: assert property (req && !wb_req.we && wb_req.adr[7:2] > 6'h11
    |=> wb_rsp.dat == 32'h0000_0000) else $error("unmapped read not zero");
  c_read_release_a: assert property (req && !wb_req.we && wb_req.adr[7:2] == IDX_CTRL_C
    |=> ##[1:2] !rtc_host_irq_n_oe) else $error("irq kept after status read");
  irq_data_a: assert property (rtc_host_irq_n_o == 1'b0)
    else $error("open drain data not low");
  xtal_inverse_a: assert property (xtal_out |-> !$past(xtal_in))
    else $error("oscillator output not inverted reference");
  bank_legal_a: assert property (bank_select != 2'h3)
    else $error("illegal bank");
  bank_change_a: assert property (!$stable(bank_select)
    |-> $past(wb_rsp.ack) || $past(wb_rsp.ack, 2)) else $error("bank moved without write");
endmodule

bind rtc_timebase_update_alarm rtc_core_checker rtc_core_checker_i (.clk(clk),
  .reset_n(reset_n), .wb_req(wb_req), .wb_rsp(wb_rsp), .xtal_in(xtal_in),
  .xtal_out(xtal_out), .rtc_host_irq_n_o(rtc_host_irq_n_o),
  .rtc_host_irq_n_oe(rtc_host_irq_n_oe), .bank_select(bank_select));

// File: bench/rtc_timebase_update_alarm_tb.sv
// Self-checking bench: bus, control A guard, banks, periodic taps, update, alarm, calendar.
// Assumes the reference model gives one tick every two clocks.
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch at %0t: got %h want %h", $time, got, exp); end end
module rtc_timebase_update_alarm_tb;
  import rtc_pkg::*;
  logic clk, reset_n, xtal_in, xtal_out, main_power_ok, vrt_in, irq_o, irq_oe, irq_wire;
  logic [1:0] bank_select;
  wb_req_type wb_req;
  wb_rsp_type wb_rsp;
  logic [7:0] q;
  int n_fail, tests_run;

  rtc_timebase_update_alarm rtc_timebase_update_alarm_i (.clk(clk), .reset_n(reset_n),
    .wb_req(wb_req), .wb_rsp(wb_rsp), .xtal_in(xtal_in), .xtal_out(xtal_out),
    .main_power_ok(main_power_ok), .vrt_in(vrt_in), .rtc_host_irq_n_o(irq_o),
    .rtc_host_irq_n_oe(irq_oe), .bank_select(bank_select));
  ref_osc_model ref_osc_model_i (.clk(clk), .xtal(xtal_in), .irq_o(irq_o), .irq_oe(irq_oe),
    .irq_wire(irq_wire));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic complete_run();
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Classic single cycle; the bound on the wait only guards against a dead slave
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx, 2'b00}, sel: 4'hF,
      dat: {24'h00_0000, d}};
    do begin
      @(posedge clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 20);
    `CHK(wb_rsp.ack, 1'b1)
    q = wb_rsp.dat[7:0];
    wb_req <= '0;
  endtask

  function automatic logic [7:0] enc(input int v, input logic bin);
    return bin ? 8'(v) : 8'((v / 10) * 16 + v % 10);
  endfunction

  function automatic logic [7:0] exp_c(input logic upd, input logic alm, input logic [7:0] rtc_control_b);
    return {(upd & rtc_control_b[4]) | (alm & rtc_control_b[5]), 1'b0, alm, upd, 4'h0};
  endfunction

  task automatic tap(input logic [3:0] r);
    int h = (r == 0) ? 64 : (1 << (r - 1));
    bus(1'b1, IDX_CTRL_A, {4'h6, r});
    bus(1'b0, IDX_CTRL_C, 8'h00);
    bus(1'b1, IDX_CTRL_A, {4'h2, r});
    repeat (h - 8) @(posedge clk);
    bus(1'b0, IDX_CTRL_C, 8'h00);
    `CHK(q[6], 1'b0)
    repeat (10) @(posedge clk);
    `CHK(irq_wire, r == 0)
    bus(1'b0, IDX_CTRL_C, 8'h00);
    `CHK(q[7:6], {2{r != 0}})
  endtask

  // Feb 28 23:59:59 (11:59:59 PM in 12 hour mode) rolls over at the first update
  task automatic day_roll(input logic bin, input int y, input logic [7:0] alm_sec,
    input logic h12);
    logic [7:0] rtc_control_b = {4'b0011, 1'b0, bin, ~h12, 1'b0};
    logic leap = (y % 4 == 0);
    logic [5:0] ti[7] = '{IDX_SEC, IDX_MIN, IDX_HOUR, IDX_WDAY, IDX_DATE, IDX_MONTH, IDX_YEAR};
    int tv[7] = '{59, 59, 23, 3, 28, 2, y};
    int ev[7] = '{0, 0, h12 ? 12 : 0, 4, leap ? 29 : 1, leap ? 2 : 3, y};
    logic [5:0] ai[6] = '{IDX_MIN_ALM, IDX_HOUR_ALM, IDX_WDAY_ALM, IDX_DATE_ALM,
      IDX_MONTH_ALM, IDX_YEAR_ALM};
    int n = 0;
    bus(1'b1, IDX_CTRL_A, 8'h60);
    bus(1'b1, IDX_CTRL_B, rtc_control_b | 8'h80);
    foreach (ti[i]) bus(1'b1, ti[i],
      (i == 2 && h12) ? (8'h80 | enc(11, bin)) : enc(tv[i], bin));
    foreach (ai[i]) bus(1'b1, ai[i], 8'hC0);
    bus(1'b1, IDX_SEC_ALM, alm_sec);
    bus(1'b1, IDX_CTRL_B, rtc_control_b);
    bus(1'b1, IDX_CTRL_A, 8'h20);
    do begin
      bus(1'b0, IDX_CTRL_A, 8'h00);
      n += 3;
    end while (q[7] !== 1'b1 && n < 40000);
    `CHK(n > 32730 && n < 32780, 1'b1)
    bus(1'b0, IDX_CTRL_C, 8'h00);
    `CHK(q[4], 1'b0)
    repeat (20) @(posedge clk);
    `CHK(irq_wire, 1'b0)
    bus(1'b0, IDX_CTRL_C, 8'h00);
    `CHK(q, exp_c(1'b1, alm_sec == 8'h00, rtc_control_b))
    repeat (2) @(posedge clk);
    `CHK(irq_wire, 1'b1)
    foreach (ti[i]) begin
      bus(1'b0, ti[i], 8'h00);
      `CHK(q, enc(ev[i], bin))
    end
  endtask

  initial begin
    repeat (95000) @(posedge clk);
    n_fail++;
    $display("mismatch at %0t: run hung", $time);
    complete_run();
  end

  initial begin
    wb_req = '0;
    main_power_ok = 1'b1;
    vrt_in = 1'b0;
    reset_n = 1'b0;
    n_fail = 0;
    tests_run = 0;
    void'($urandom(32'h3778_084a));
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    bus(1'b0, IDX_CTRL_A, 8'h00);
    `CHK(q, {1'b0, CTRL_A_RESET})
    bus(1'b0, IDX_CTRL_B, 8'h00);
    `CHK(q, CTRL_B_RESET)
    bus(1'b0, 6'h3F, 8'h00);
    `CHK(q, 8'h00)
    bus(1'b1, IDX_CTRL_A, 8'h70);
    bus(1'b0, IDX_CTRL_A, 8'h00);
    `CHK(q, 8'h20)
    vrt_in <= 1'b1;
    repeat (2) @(posedge clk);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, IDX_CTRL_A, {1'b0, 3'(c), 4'h0});
      bus(1'b0, IDX_CTRL_A, 8'h00);
      `CHK(q[6:0], {3'(c), 4'h0})
      `CHK(bank_select, c[2] ? 2'h2 : {1'b0, c[0]})
    end
    // Code 000 with main power gone stops the oscillator; 010 restarts it
    bus(1'b1, IDX_CTRL_A, 8'h00);
    main_power_ok <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(xtal_out, 1'b0)
    bus(1'b1, IDX_CTRL_A, 8'h20);
    repeat (2) @(posedge clk);
    q[0] = xtal_out;
    @(posedge clk);
    `CHK(xtal_out, ~q[0])
    main_power_ok <= 1'b1;
    bus(1'b1, IDX_CTRL_B, 8'h42);
    for (int r = 0; r < 8; r++) if (r == 0 || r > 3) tap(4'(r));
    tap(4'(8 + $urandom % 3));
    bus(1'b1, IDX_CTRL_B, 8'h02);
    day_roll(1'b0, int'($urandom % 100), 8'h00, 1'b0);
    day_roll(1'b1, 0, 8'h01, 1'b1);
    complete_run();
  end
endmodule
